// *** aps_buf.sv ***
// Shared definitions for the attachment-unit signaling block and its two-entry buffer.
`timescale 1ns/100ps
package aps_pkg;
    // ---------------------------------------------------------------
    // Line symbols and unit codes.
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {SYM_IDLE, SYM_ZERO, SYM_ONE} aps_sym_e;
    typedef enum logic [1:0] {UNIT_ZERO, UNIT_ONE, UNIT_DONE} aps_unit_e;
    typedef enum logic [1:0] {RESP_SIMPLE, RESP_ISOLATE, RESP_COND, RESP_INCOMPAT} aps_resp_e;
    typedef struct packed {
        aps_sym_e data;
        aps_sym_e ctrl;
    } aps_line_s;
    // ---------------------------------------------------------------
    // Timing and capability constants.
    // ---------------------------------------------------------------
    localparam int         CLK_PERIOD_PS = 8000;
    localparam int         BIT_TIME_PS   = 100000;
    localparam logic [7:0] BIT_CYCLES    = 8'((BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int         SETTLE_BITS   = 16;
    localparam int         PROBE_BITS    = 32;
    localparam logic [11:0] SETTLE_CYCLES = 12'(SETTLE_BITS * int'(BIT_CYCLES));
    localparam logic [11:0] PROBE_CYCLES  = 12'(PROBE_BITS * int'(BIT_CYCLES));
    localparam logic       DTE_ISOLATE   = 1'b1;
    localparam logic       DTE_COND      = 1'b1;
    localparam int         UNIT_W        = 2;
    localparam int         SYNC_W        = 5;
endpackage

// Two-entry buffer in the output data path.
module aps_buf #(
    parameter int W = 2
) (
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         clr_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic         wr_q, wr_d, rd_q, rd_d;
    logic [1:0]   cnt_q, cnt_d;
    logic         push, pop;

    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
            wr_d        = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        if (clr_in) begin
            wr_d  = 1'b0;
            rd_d  = 1'b0;
            cnt_d = 2'h0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// *** aps_top.sv ***
// Terminal-side physical signaling logic for the attachment unit interface.
//
// Notes on behaviour
// - Data-in content is ignored while signal quality error is shown.
// - ONE maps to one-symbol, ZERO to zero-symbol, done to idle on data-out.
// - Each output unit gets exactly one status, next or abort.
// - Each bit received while no signal quality error is shown yields one input unit with the same value.
// - Carrier turns on with bit or error, off with idle and no error.
// - Signal error reported on error onset, cleared when it vanishes.
// - A management reset request clears the buffer, transmitter, carrier and error state and restarts identify.
// - A reset response follows every completed reset and identify sequence.
// - The response reports simple, isolate or conditioned operation.
// - The response reports incompatible when conditioning is needed but unsupported.
// - Each output bit lasts a full bit time before the next starts.
// - A request on control-out stays until the MAC sends done.
`timescale 1ns/100ps
module aps_top
    import aps_pkg::*;
(
    input  wire logic               CLK_IN,
    input  wire logic               RESET_N_IN,
    input  wire logic               RESET_REQ_IN,
    input  wire aps_sym_e           DATA_IN_SYM_IN,
    input  wire logic               DATA_IN_TGL_IN,
    input  wire aps_sym_e           CTRL_IN_SYM_IN,
    output aps_pkg::aps_line_s      LINE_OUT,
    input  wire logic               OUT_VALID_IN,
    input  wire aps_pkg::aps_unit_e OUT_UNIT_IN,
    output logic                    OUT_READY_OUT,
    output logic                    OUT_STATUS_VALID_OUT,
    output logic                    OUT_STATUS_ABORT_OUT,
    output logic                    IN_VALID_OUT,
    output logic                    IN_BIT_OUT,
    output logic                    CARRIER_ON_OUT,
    output logic                    CARRIER_CHG_OUT,
    output logic                    SIGNAL_ERR_OUT,
    output logic                    SIGNAL_CHG_OUT,
    output logic                    RESP_VALID_OUT,
    output aps_pkg::aps_resp_e      RESP_CODE_OUT
);
    import aps_pkg::*;

    typedef enum logic [1:0] {ST_SETTLE, ST_PROBE, ST_REQ, ST_OPER} aps_id_e;
    typedef enum logic [1:0] {TX_IDLE, TX_REQ, TX_BIT} aps_tx_e;

    logic srst;
    assign srst = RESET_REQ_IN;

    // ---------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree.
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, acc_q, acc_d, pin_raw;
    assign pin_raw = {DATA_IN_TGL_IN, DATA_IN_SYM_IN, CTRL_IN_SYM_IN};

    always_comb begin
        acc_d = acc_q;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                acc_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            acc_q <= '0;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            acc_q <= acc_d;
        end
    end

    aps_sym_e di_sym, ci_sym;
    logic     tgl_seen_q, bit_ev, sqe, di_idle;
    assign di_sym  = aps_sym_e'(acc_q[3:2]);
    assign ci_sym  = aps_sym_e'(acc_q[1:0]);
    assign bit_ev  = (acc_q[4] != tgl_seen_q) && (di_sym != SYM_IDLE);
    assign sqe     = (ci_sym == SYM_ZERO);
    assign di_idle = (di_sym == SYM_IDLE);

    // ---------------------------------------------------------------
    // Input, carrier and signal status.
    // ---------------------------------------------------------------
    logic tgl_seen_d, in_valid_q, in_valid_d, in_bit_q, in_bit_d;
    logic car_q, car_d, car_chg_q, car_chg_d, err_q, err_d, err_chg_q, err_chg_d;

    always_comb begin
        tgl_seen_d = acc_q[4];
        in_valid_d = bit_ev && !sqe;
        in_bit_d   = (di_sym == SYM_ONE);
        car_d      = car_q;
        err_d      = err_q;
        if (!car_q && (bit_ev || sqe)) begin
            car_d = 1'b1;
        end else if (car_q && di_idle && !sqe) begin
            car_d = 1'b0;
        end
        if (sqe != err_q) begin
            err_d = sqe;
        end
        car_chg_d = (car_d != car_q);
        err_chg_d = (err_d != err_q);
        if (srst) begin
            in_valid_d = 1'b0;
            car_d      = 1'b0;
            err_d      = 1'b0;
            car_chg_d  = 1'b0;
            err_chg_d  = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tgl_seen_q <= 1'b0;
            in_valid_q <= 1'b0;
            in_bit_q   <= 1'b0;
            car_q      <= 1'b0;
            car_chg_q  <= 1'b0;
            err_q      <= 1'b0;
            err_chg_q  <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_seen_d;
            in_valid_q <= in_valid_d;
            in_bit_q   <= in_bit_d;
            car_q      <= car_d;
            car_chg_q  <= car_chg_d;
            err_q      <= err_d;
            err_chg_q  <= err_chg_d;
        end
    end

    // ---------------------------------------------------------------
    // Reset and identify sequence.
    // ---------------------------------------------------------------
    aps_id_e   id_q, id_d;
    logic [11:0] idc_q, idc_d;
    logic      cond_q, cond_d, resp_v_q, resp_v_d, probe_seen_q, probe_seen_d;
    aps_resp_e resp_q, resp_d;
    logic      op;
    assign op = (id_q == ST_OPER) && (resp_q != RESP_INCOMPAT);

    always_comb begin
        id_d         = id_q;
        idc_d        = idc_q - 12'h1;
        cond_d       = cond_q;
        resp_d       = resp_q;
        resp_v_d     = 1'b0;
        probe_seen_d = probe_seen_q;
        unique case (id_q)
            ST_SETTLE: begin
                if (idc_q == 12'h0) begin
                    idc_d        = PROBE_CYCLES;
                    probe_seen_d = 1'b0;
                    if (ci_sym == SYM_ONE && DTE_ISOLATE) begin
                        id_d = ST_REQ;
                    end else begin
                        id_d     = ST_OPER;
                        resp_d   = RESP_SIMPLE;
                        resp_v_d = 1'b1;
                    end
                end
            end
            ST_REQ: begin
                if (ci_sym == SYM_IDLE) begin
                    probe_seen_d = 1'b1;
                end
                if (idc_q == 12'h0) begin
                    id_d  = ST_PROBE;
                    idc_d = PROBE_CYCLES;
                end
            end
            ST_PROBE: begin
                if (idc_q == 12'h0) begin
                    id_d     = ST_OPER;
                    resp_v_d = 1'b1;
                    if (!probe_seen_q) begin
                        resp_d = RESP_ISOLATE;
                    end else if (DTE_COND) begin
                        resp_d = RESP_COND;
                        cond_d = 1'b1;
                    end else begin
                        resp_d = RESP_INCOMPAT;
                    end
                end
            end
            ST_OPER: begin
                idc_d = idc_q;
            end
        endcase
        if (srst) begin
            id_d   = ST_SETTLE;
            idc_d  = SETTLE_CYCLES;
            cond_d   = 1'b0;
            resp_d   = RESP_SIMPLE;
            resp_v_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            id_q         <= ST_SETTLE;
            idc_q        <= SETTLE_CYCLES;
            cond_q       <= 1'b0;
            resp_q       <= RESP_SIMPLE;
            resp_v_q     <= 1'b0;
            probe_seen_q <= 1'b0;
        end else begin
            id_q         <= id_d;
            idc_q        <= idc_d;
            cond_q       <= cond_d;
            resp_q       <= resp_d;
            resp_v_q     <= resp_v_d;
            probe_seen_q <= probe_seen_d;
        end
    end

    // ---------------------------------------------------------------
    // Output path: buffer, status and bit-cell transmitter.
    // ---------------------------------------------------------------
    logic      buf_in_ready, buf_valid, pop, in_fire;
    aps_unit_e buf_unit;
    logic [UNIT_W-1:0] buf_data;
    assign buf_unit      = aps_unit_e'(buf_data);
    assign OUT_READY_OUT = op ? buf_in_ready : 1'b1;
    assign in_fire       = OUT_VALID_IN && OUT_READY_OUT;

    aps_buf #(.W(UNIT_W)) u_buf (
        .clk_in        (CLK_IN),
        .reset_n_in    (RESET_N_IN),
        .clr_in        (srst),
        .in_valid_in   (OUT_VALID_IN && op),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (OUT_UNIT_IN),
        .out_valid_out (buf_valid),
        .out_ready_in  (pop),
        .out_data_out  (buf_data)
    );

    aps_tx_e   tx_q, tx_d;
    logic [7:0] bc_q, bc_d;
    aps_sym_e  do_q, do_d;
    logic      req_q, req_d, st_v_q, st_v_d, st_ab_q, st_ab_d, can_send, at_edge;
    assign can_send = !(cond_q && ci_sym == SYM_ONE);
    assign at_edge  = (tx_q != TX_BIT) || (bc_q == 8'h0);

    always_comb begin
        tx_d    = tx_q;
        bc_d    = bc_q - 8'h1;
        do_d    = do_q;
        req_d   = req_q;
        pop     = 1'b0;
        st_v_d  = in_fire;
        st_ab_d = !op;
        if (at_edge) begin
            bc_d = 8'h0;
            tx_d = TX_IDLE;
            if (tx_q == TX_BIT) begin
                do_d = SYM_IDLE;
            end
            if (buf_valid) begin
                if (buf_unit == UNIT_DONE) begin
                    pop   = 1'b1;
                    do_d  = SYM_IDLE;
                    req_d = 1'b0;
                end else if (!can_send) begin
                    tx_d  = TX_REQ;
                    req_d = 1'b1;
                    do_d  = SYM_IDLE;
                end else begin
                    pop  = 1'b1;
                    tx_d = TX_BIT;
                    bc_d = BIT_CYCLES - 8'h1;
                    do_d = (buf_unit == UNIT_ONE) ? SYM_ONE : SYM_ZERO;
                end
            end
        end
        if (srst) begin
            tx_d   = TX_IDLE;
            bc_d   = 8'h0;
            do_d   = SYM_IDLE;
            req_d  = 1'b0;
            st_v_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_q    <= TX_IDLE;
            bc_q    <= 8'h0;
            do_q    <= SYM_IDLE;
            req_q   <= 1'b0;
            st_v_q  <= 1'b0;
            st_ab_q <= 1'b0;
        end else begin
            tx_q    <= tx_d;
            bc_q    <= bc_d;
            do_q    <= do_d;
            req_q   <= req_d;
            st_v_q  <= st_v_d;
            st_ab_q <= st_ab_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs.
    // ---------------------------------------------------------------
    assign LINE_OUT.data        = do_q;
    assign LINE_OUT.ctrl        = (req_q || id_q == ST_REQ) ? SYM_ONE : SYM_IDLE;
    assign OUT_STATUS_VALID_OUT = st_v_q;
    assign OUT_STATUS_ABORT_OUT = st_ab_q;
    assign IN_VALID_OUT         = in_valid_q;
    assign IN_BIT_OUT           = in_bit_q;
    assign CARRIER_ON_OUT       = car_q;
    assign CARRIER_CHG_OUT      = car_chg_q;
    assign SIGNAL_ERR_OUT       = err_q;
    assign SIGNAL_CHG_OUT       = err_chg_q;
    assign RESP_VALID_OUT       = resp_v_q;
    assign RESP_CODE_OUT        = resp_q;

    // ---------------------------------------------------------------
    // Assertions.
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    sqe_block_a: assert property (sqe && !srst |=> !in_valid_q)
        else $error("Input unit delivered during signal quality error.");
    map_bit_a: assert property (pop && buf_unit == UNIT_ONE && !srst |=> do_q == SYM_ONE)
        else $error("ONE unit not mapped to one-symbol.");
    status_once_a: assert property (in_fire && !srst |=> st_v_q && st_ab_q == !$past(op))
        else $error("Output unit without matching status.");
    rx_unit_a: assert property (bit_ev && !sqe && !srst |=> in_valid_q && in_bit_q == (($past(di_sym)) == SYM_ONE))
        else $error("Received bit not delivered correctly.");
    carrier_rise_a: assert property ($rose(car_q) |-> $past(bit_ev || sqe) && car_chg_q)
        else $error("Carrier raised without cause.");
    signal_err_a: assert property (!err_q && sqe && !srst |=> err_q && err_chg_q)
        else $error("Signal error not reported on onset.");
    reset_req_a: assert property (srst |=> id_q == ST_SETTLE && !car_q && !err_q && do_q == SYM_IDLE)
        else $error("Reset request did not clear state.");
    resp_done_a: assert property (resp_v_q |-> id_q == ST_OPER && $past(id_q) != ST_OPER)
        else $error("Reset response outside completion of identify.");
    bit_cell_a: assert property (tx_q == TX_BIT && bc_q != 8'h0 && !srst |=> $stable(do_q))
        else $error("Output bit cut short.");
    req_hold_a: assert property (req_q && !(pop && buf_unit == UNIT_DONE) && !srst |=> req_q)
        else $error("Request dropped before data complete.");

    cov_tx_bit_c: cover property (pop && buf_unit != UNIT_DONE ##[1:20] pop && buf_unit == UNIT_DONE);
    cov_carrier_c: cover property ($rose(car_q) ##[1:200] $fell(car_q));
    cov_cond_c: cover property (resp_v_q && resp_q == RESP_COND);
endmodule

// *** aps_mau_model.sv ***
// Behavioural attachment unit answering the terminal-side signaling block.
`timescale 1ns/100ps
module aps_mau_model
    import aps_pkg::*;
(
    input  wire logic       clk_in,
    input  wire aps_line_s  line_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       sqe_in,
    output aps_sym_e        data_sym_out,
    output logic            tgl_out,
    output aps_sym_e        ctrl_sym_out
);
    logic       busy_q = 1'b0;
    logic       seen_q = 1'b0;
    logic [3:0] sqe_q  = 4'h0;

    initial begin
        data_sym_out = SYM_IDLE;
        tgl_out = 1'b0;
    end

    // Sends one symbol per bit, each held a bit time, and idle afterwards.
    task automatic rx_bits(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            data_sym_out <= b[i] ? SYM_ONE : SYM_ZERO;
            tgl_out <= ~tgl_out;
            repeat (12) @(posedge clk_in);
        end
        @(posedge clk_in);
        data_sym_out <= SYM_IDLE;
    endtask

    // Mode 1 shows not-available throughout, mode 2 whenever no request is held.
    always @(posedge clk_in) begin
        busy_q <= line_in.data != SYM_IDLE;
        seen_q <= (mode_in == 2'h2) && (line_in.ctrl == SYM_ONE);
        if (busy_q && line_in.data == SYM_IDLE) begin
            sqe_q <= 4'ha;
        end else if (sqe_q != 4'h0) begin
            sqe_q <= sqe_q - 4'h1;
        end
    end

    always_comb begin
        if (sqe_in || sqe_q != 4'h0) begin
            ctrl_sym_out = SYM_ZERO;
        end else if (mode_in == 2'h1 || (mode_in == 2'h2 && !seen_q)) begin
            ctrl_sym_out = SYM_ONE;
        end else begin
            ctrl_sym_out = SYM_IDLE;
        end
    end
endmodule

// *** aui_physical_signaling_tb_top.sv ***
// Self-checking bench for the terminal-side signaling block.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define TAKE(q, g) begin if (q.size() == 0) `CHK(g, 2'bxx) else `CHK(g, q.pop_front()) end
module aui_physical_signaling_tb_top;
    import aps_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n, rq, vld, sqe, tgl, rdy, st_v, st_ab, in_v, in_b;
    logic       car, car_c, sig, sig_c, rsp_v;
    logic [1:0] mode;
    aps_unit_e  unit;
    aps_sym_e   dsym, csym;
    aps_line_s  line;
    aps_resp_e  rsp;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    logic [1:0] qo[$], qd[$], qi[$], qc[$], qs[$], qr[$];
    logic [3:0] dcnt = 4'h0;
    logic       dbusy = 1'b0;
    aps_sym_e   ctrl_exp = SYM_IDLE;

    initial begin
        forever #4 clk = ~clk;
    end

    aps_top u_dut (
        .CLK_IN               (clk),
        .RESET_N_IN           (rst_n),
        .RESET_REQ_IN         (rq),
        .DATA_IN_SYM_IN       (dsym),
        .DATA_IN_TGL_IN       (tgl),
        .CTRL_IN_SYM_IN       (csym),
        .LINE_OUT             (line),
        .OUT_VALID_IN         (vld),
        .OUT_UNIT_IN          (unit),
        .OUT_READY_OUT        (rdy),
        .OUT_STATUS_VALID_OUT (st_v),
        .OUT_STATUS_ABORT_OUT (st_ab),
        .IN_VALID_OUT         (in_v),
        .IN_BIT_OUT           (in_b),
        .CARRIER_ON_OUT       (car),
        .CARRIER_CHG_OUT      (car_c),
        .SIGNAL_ERR_OUT       (sig),
        .SIGNAL_CHG_OUT       (sig_c),
        .RESP_VALID_OUT       (rsp_v),
        .RESP_CODE_OUT        (rsp)
    );

    aps_mau_model u_mau (
        .clk_in       (clk),
        .line_in      (line),
        .mode_in      (mode),
        .sqe_in       (sqe),
        .data_sym_out (dsym),
        .tgl_out      (tgl),
        .ctrl_sym_out (csym)
    );

    // ---------------------------------------------------------------
    // Drivers.
    // ---------------------------------------------------------------
    task automatic send(input aps_unit_e u, input logic ab, input logic live);
        int k;
        qo.push_back({1'b0, ab});
        if (live) qd.push_back(u == UNIT_ONE ? SYM_ONE : (u == UNIT_ZERO ? SYM_ZERO : SYM_IDLE));
        @(posedge clk);
        vld <= 1'b1;
        unit <= u;
        k = 0;
        do begin @(negedge clk); k++; end while (rdy !== 1'b1 && k < 400);
        @(posedge clk);
        vld <= 1'b0;
        k = 0;
        do begin @(negedge clk); k++; end while (st_v !== 1'b1 && k < 400);
    endtask

    task automatic drain(input int n);
        for (int i = 0; i < n; i++) begin
            if (qo.size() + qd.size() + qi.size() + qc.size() + qs.size() + qr.size() == 0) break;
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
    endtask

    task automatic reset_req(input logic [1:0] m, input logic [1:0] code);
        @(posedge clk) mode <= m;
        qr.push_back(code);
        @(posedge clk) rq <= 1'b1;
        @(posedge clk) rq <= 1'b0;
        drain(3000);
    endtask

    task automatic rx(input int n, input logic [7:0] b);
        qc.push_back(2'h1);
        for (int i = 0; i < n; i++) qi.push_back({1'b0, b[i]});
        qc.push_back(2'h0);
        u_mau.rx_bits(n, b);
        drain(600);
    endtask

    // Eight random bits and a done unit; c is the control-out symbol expected under the bits.
    task automatic frame(input aps_sym_e c);
        ctrl_exp = c;
        for (int i = 0; i < 8; i++) send(($urandom % 2) != 0 ? UNIT_ONE : UNIT_ZERO, 1'b0, 1'b1);
        qc.push_back(2'h1);
        qs.push_back(2'h1);
        qs.push_back(2'h0);
        qc.push_back(2'h0);
        send(UNIT_DONE, 1'b0, 1'b1);
        drain(800);
        ctrl_exp = SYM_IDLE;
    endtask

    task wrap_up;
        `CHK(qo.size() + qd.size() + qi.size() + qc.size() + qs.size() + qr.size(), 0)
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Output watcher.
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_n === 1'b1) begin
            if (st_v === 1'b1) `TAKE(qo, {1'b0, st_ab})
            if (in_v === 1'b1) `TAKE(qi, {1'b0, in_b})
            if (car_c === 1'b1) `TAKE(qc, {1'b0, car})
            if (sig_c === 1'b1) `TAKE(qs, {1'b0, sig})
            if (rsp_v === 1'b1) `TAKE(qr, rsp)
            if (dcnt != 4'h0) begin
                dcnt <= dcnt - 4'h1;
            end else if (line.data != SYM_IDLE) begin
                `TAKE(qd, line.data)
                `CHK(line.ctrl, ctrl_exp)
                dcnt <= 4'hc;
                dbusy <= 1'b1;
            end else if (dbusy) begin
                `TAKE(qd, SYM_IDLE)
                dbusy <= 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'he7ac));
        rst_n = 1'b0;
        rq = 1'b0;
        vld = 1'b0;
        unit = UNIT_ZERO;
        mode = 2'h0;
        sqe = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        qr.push_back(RESP_SIMPLE);
        send(UNIT_ZERO, 1'b1, 1'b0);
        drain(3000);
        frame(SYM_IDLE);
        frame(SYM_IDLE);
        rx(8, 8'($urandom));
        rx(1, 8'h01);
        reset_req(2'h1, RESP_ISOLATE);
        reset_req(2'h2, RESP_COND);
        frame(SYM_ONE);
        reset_req(2'h0, RESP_SIMPLE);
        qc.push_back(2'h1);
        qs.push_back(2'h1);
        qs.push_back(2'h0);
        qc.push_back(2'h0);
        @(posedge clk) sqe <= 1'b1;
        u_mau.rx_bits(3, 8'h05);
        @(posedge clk) sqe <= 1'b0;
        drain(600);
        wrap_up;
    end
endmodule
